// ---- prot_lock_pkg.sv ----
// Purpose: Shared constants for the sector protection lock control block
// Assumes: Serial link in mode 0 or 3, most significant bit first
// Notes:   Status byte layout and opcodes live here
package prot_lock_pkg;
  localparam int          NUM_SECTORS   = 128;
  localparam int          SEC_IDX_W     = 7;
  localparam int          SEC_ADDR_LSB  = 16;
  localparam int          SEC_ADDR_MSB  = 22;
  localparam logic [7:0]  OP_WR_STATUS  = 8'h01;
  localparam logic [7:0]  OP_RD_STATUS  = 8'h05;
  localparam logic [7:0]  OP_WR_DISABLE = 8'h04;
  localparam logic [7:0]  OP_WR_ENABLE  = 8'h06;
  localparam logic [7:0]  OP_RD_PROT    = 8'h3c;
  localparam logic [5:0]  CNT_OPCODE    = 6'h08;
  localparam logic [5:0]  CNT_WR_DATA   = 6'h10;
  localparam logic [5:0]  CNT_ADDR_DONE = 6'h20;
  localparam logic [5:0]  CNT_WRAP_LAST = 6'h27;
  localparam logic [3:0]  GLOBAL_CLEAR  = 4'h0;
  localparam logic [3:0]  GLOBAL_SET    = 4'hf;
  localparam int          ST_LOCK_BIT   = 7;
  localparam int          ST_WP_BIT     = 4;
  localparam int          ST_WEL_BIT    = 1;
  localparam int          ST_GLOB_MSB   = 5;
  localparam int          ST_GLOB_LSB   = 2;
  localparam logic [1:0]  SUM_NONE      = 2'h0;
  localparam logic [1:0]  SUM_SOME      = 2'h1;
  localparam logic [1:0]  SUM_ALL       = 2'h3;
  localparam logic [3:0]  PIN_SYNC_RST  = 4'he;
  localparam logic        LOCK_RST      = 1'h0;
  localparam logic        PROT_RST      = 1'h1;
endpackage

// ---- link_pin_sync.sv ----
// Purpose: Two-flop synchronisers plus one delay stage for edge finding
// Assumes: Inputs are asynchronous pins
// Notes:   Only the second stage and delay stage are visible outside
`timescale 1ns/10ps
module link_pin_sync
  import prot_lock_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  input  wire logic [3:0] pins_i,
  output logic      [3:0] sync_o,
  output logic      [3:0] prev_o
);
  logic [3:0] meta_ff;
  logic [3:0] sync_ff;
  logic [3:0] prev_ff;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_ff <= PIN_SYNC_RST;
      sync_ff <= PIN_SYNC_RST;
      prev_ff <= PIN_SYNC_RST;
    end else begin
      meta_ff <= pins_i;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign sync_o = sync_ff;
  assign prev_o = prev_ff;
endmodule // link_pin_sync

// ---- sector_prot_array.sv ----
// Purpose: Per-sector software protection bits with global set and clear
// Assumes: Set and clear are never both high
// Notes:   Summary flags feed the status byte
`timescale 1ns/10ps
module sector_prot_array
  import prot_lock_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 nrst_i,
  input  wire logic                 set_all_i,
  input  wire logic                 clr_all_i,
  input  wire logic [SEC_IDX_W-1:0] sel_i,
  output logic                      sel_bit_o,
  output logic                      all_set_o,
  output logic                      any_set_o
);
  logic [NUM_SECTORS-1:0] prot_ff;

  genvar g;
  generate
    for (g = 0; g < NUM_SECTORS; g++) begin : g_sec
      always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          prot_ff[g] <= PROT_RST;
        end else if (set_all_i) begin
          prot_ff[g] <= 1'b1;
        end else if (clr_all_i) begin
          prot_ff[g] <= 1'b0;
        end
      end
    end
  endgenerate

  assign sel_bit_o = prot_ff[sel_i];
  assign all_set_o = &prot_ff;
  assign any_set_o = |prot_ff;
endmodule // sector_prot_array

// ---- sector_protect_lock_control.sv ----
// Purpose: Global protect decode, lock bit and protection readback over a serial link
// Assumes: Link pins are asynchronous; serial clock well below a quarter of CLK_SYS_I
// Notes:   Mode 0 and 3 framing; status write takes effect at chip select release
// Functional notes
// - Bits five-two all zero clears, all one sets
// - Soft lock blocks any global protect change
// - Soft lock still loads bit seven into lock
// - 00h unlocked clears all, lock stays zero
// - 7Fh unlocked sets all, lock stays zero
// - FFh unlocked sets all and sets lock
// - 0Fh clears lock only with pin high
// - F0h sets lock, protection untouched
// - Only bit seven is stored on write
// - Read bits four-two show pin and summary
// - Repeat FFh if protected, else 00h
// - Fast clock: first output byte invalid, skip it
// - Chip select release ends read, output floats
// - Readback carries only sector software bit
// - Status shows all, some or none protected
// - Pin low with lock set hard-locks lock bit and protection
// - Global protect during suspend aborts, clears latch
`timescale 1ns/10ps
module sector_protect_lock_control
  import prot_lock_pkg::*;
(
  input  wire logic CLK_SYS_I,
  input  wire logic NRST_I,
  input  wire logic CS_N_I,
  input  wire logic SCK_I,
  input  wire logic SI_I,
  input  wire logic WP_N_I,
  input  wire logic SUSPEND_ACTIVE_I,
  output logic      SO_O,
  output logic      SO_OE_O,
  output logic      PROTECTION_LOCK_BIT_O,
  output logic      WRITE_ENABLE_LATCH_O
);
  logic [3:0]           pin_sync;
  logic [3:0]           pin_prev;
  logic [5:0]           bit_cnt_ff;
  logic [31:0]          shift_ff;
  logic [7:0]           opcode_ff;
  logic [7:0]           wdata_ff;
  logic                 wdata_ok_ff;
  logic [SEC_IDX_W-1:0] sector_ff;
  logic                 lock_ff;
  logic                 wel_ff;
  logic                 so_ff;
  logic                 drive_ff;
  logic                 nxt_lock;
  logic                 nxt_wel;

  link_pin_sync u_sync (
    .clk_i  (CLK_SYS_I),
    .nrst_i (NRST_I),
    .pins_i ({WP_N_I, CS_N_I, SCK_I, SI_I}),
    .sync_o (pin_sync),
    .prev_o (pin_prev)
  );

  wire        si_s      = pin_sync[0];
  wire        sck_rise  = pin_sync[1] & ~pin_prev[1];
  wire        sck_fall  = ~pin_sync[1] & pin_prev[1];
  wire        cs_act    = ~pin_sync[2];
  wire        cs_end    = pin_sync[2] & ~pin_prev[2];
  wire        wp_high   = pin_sync[3];
  wire [31:0] shift_nxt = {shift_ff[30:0], si_s};
  wire [5:0]  cnt_inc   = (bit_cnt_ff == CNT_WRAP_LAST) ? CNT_ADDR_DONE : bit_cnt_ff + 6'h01;

  // Lock state from pin and lock bit
  wire        hard_lock = ~wp_high & lock_ff;
  wire        soft_lock = wp_high & lock_ff;
  wire [3:0]  glob_bits = wdata_ff[ST_GLOB_MSB:ST_GLOB_LSB];

  // Status write decode at chip select release
  wire        wr_apply  = cs_end & (opcode_ff == OP_WR_STATUS) & wdata_ok_ff & wel_ff;
  wire        want_set  = wr_apply & ~lock_ff & (glob_bits == GLOBAL_SET);
  wire        want_clr  = wr_apply & ~lock_ff & (glob_bits == GLOBAL_CLEAR);
  wire        set_abort = want_set & SUSPEND_ACTIVE_I;
  wire        do_set    = want_set & ~SUSPEND_ACTIVE_I;
  wire        do_clr    = want_clr;
  wire        op_wren   = cs_end & (bit_cnt_ff == CNT_OPCODE) & (opcode_ff == OP_WR_ENABLE);
  wire        op_wrdis  = cs_end & (bit_cnt_ff == CNT_OPCODE) & (opcode_ff == OP_WR_DISABLE);

  logic       sel_bit;
  logic       all_set;
  logic       any_set;

  sector_prot_array u_prot (
    .clk_i     (CLK_SYS_I),
    .nrst_i    (NRST_I),
    .set_all_i (do_set),
    .clr_all_i (do_clr),
    .sel_i     (sector_ff),
    .sel_bit_o (sel_bit),
    .all_set_o (all_set),
    .any_set_o (any_set)
  );

  // Status byte as read back
  wire [1:0]  summary     = all_set ? SUM_ALL : (any_set ? SUM_SOME : SUM_NONE);
  wire [7:0]  status_byte = {lock_ff, 2'h0, ~wp_high, summary, wel_ff, 1'h0};

  // Output byte select for the two read commands
  wire        rd_prot_ph  = (opcode_ff == OP_RD_PROT) & (bit_cnt_ff >= CNT_ADDR_DONE);
  wire        rd_stat_ph  = (opcode_ff == OP_RD_STATUS) & (bit_cnt_ff >= CNT_OPCODE);
  wire        out_phase   = cs_act & (rd_prot_ph | rd_stat_ph);
  wire [7:0]  out_byte    = rd_prot_ph ? {8{sel_bit}} : status_byte;
  wire [2:0]  out_idx     = ~bit_cnt_ff[2:0];

  // Lock bit and latch next values
  always_comb begin
    nxt_lock = lock_ff;
    nxt_wel  = wel_ff;
    if (op_wren) begin
      nxt_wel = 1'b1;
    end else if (op_wrdis) begin
      nxt_wel = 1'b0;
    end else if (wr_apply) begin
      nxt_wel = 1'b0;
      if (!hard_lock && !set_abort) begin
        nxt_lock = wdata_ff[ST_LOCK_BIT];
      end
    end
  end

  // Serial input framing
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      bit_cnt_ff  <= 6'h00;
      shift_ff    <= 32'h0;
      opcode_ff   <= 8'h00;
      wdata_ff    <= 8'h00;
      wdata_ok_ff <= 1'b0;
      sector_ff   <= '0;
    end else if (!cs_act) begin
      bit_cnt_ff  <= 6'h00;
      if (!cs_end) begin
        wdata_ok_ff <= 1'b0;
        opcode_ff   <= 8'h00;
      end
    end else if (sck_rise) begin
      bit_cnt_ff <= cnt_inc;
      shift_ff   <= shift_nxt;
      if (bit_cnt_ff == CNT_OPCODE - 6'h01) begin
        opcode_ff <= shift_nxt[7:0];
      end
      if (bit_cnt_ff == CNT_WR_DATA - 6'h01) begin
        wdata_ff    <= shift_nxt[7:0];
        wdata_ok_ff <= 1'b1;
      end
      if (bit_cnt_ff == CNT_ADDR_DONE - 6'h01) begin
        sector_ff <= shift_nxt[SEC_ADDR_MSB:SEC_ADDR_LSB];
      end
    end
  end

  // Lock and latch registers
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      lock_ff <= LOCK_RST;
      wel_ff  <= 1'b0;
    end else begin
      lock_ff <= nxt_lock;
      wel_ff  <= nxt_wel;
    end
  end

  // Serial output on falling serial clock edges
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      so_ff    <= 1'b0;
      drive_ff <= 1'b0;
    end else if (!cs_act) begin
      drive_ff <= 1'b0;
    end else if (sck_fall && out_phase) begin
      so_ff    <= out_byte[out_idx];
      drive_ff <= 1'b1;
    end
  end

  assign SO_O                  = so_ff;
  assign SO_OE_O               = drive_ff & cs_act;
  assign PROTECTION_LOCK_BIT_O = lock_ff;
  assign WRITE_ENABLE_LATCH_O  = wel_ff;

  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!NRST_I);

  glob_unprot_a: assert property (
    do_clr |=> !any_set
  ) else $error("global unprotect left a sector protected");

  glob_prot_a: assert property (
    do_set |=> all_set
  ) else $error("global protect left a sector unprotected");

  soft_lock_a: assert property (
    (wr_apply && soft_lock) |=> ($stable(all_set) && $stable(any_set))
  ) else $error("protection changed while soft locked");

  lock_load_a: assert property (
    (wr_apply && soft_lock) |=> (lock_ff == $past(wdata_ff[ST_LOCK_BIT]))
  ) else $error("lock bit not loaded under soft lock");

  hard_lock_a: assert property (
    (cs_end && hard_lock) |=> ($stable(lock_ff) && $stable(all_set) && $stable(any_set))
  ) else $error("state changed while hard locked");

  oe_release_a: assert property (
    !cs_act |=> !drive_ff
  ) else $error("output driver kept on after chip select release");

  prot_byte_a: assert property (
    (sck_fall && out_phase && rd_prot_ph) |=> (SO_O == $past(sel_bit))
  ) else $error("protection readback bit wrong");

  suspend_abort_a: assert property (
    set_abort |=> (!wel_ff && $stable(all_set) && $stable(lock_ff))
  ) else $error("global protect not aborted during suspend");

  apply_end_a: assert property (
    (!cs_end) |=> $stable(lock_ff)
  ) else $error("lock bit changed outside chip select release");

  summary_bits_a: assert property (
    (all_set |-> status_byte[ST_GLOB_LSB+1:ST_GLOB_LSB] == SUM_ALL)
  ) else $error("summary field does not show all protected");

  sum_none_a: assert property (
    !any_set |-> (status_byte[ST_GLOB_LSB+1:ST_GLOB_LSB] == SUM_NONE)
  ) else $error("summary field does not show none protected");

  sum_some_a: assert property (
    (any_set && !all_set) |-> (status_byte[ST_GLOB_LSB+1:ST_GLOB_LSB] == SUM_SOME)
  ) else $error("summary field does not show some protected");

  glob_keep_a: assert property (
    (wr_apply && !lock_ff && (glob_bits != GLOBAL_SET) && (glob_bits != GLOBAL_CLEAR))
      |=> ($stable(all_set) && $stable(any_set))
  ) else $error("other pattern changed protection");

  soft_noset_a: assert property (
    (wr_apply && lock_ff) |-> (!do_set && !do_clr)
  ) else $error("global change requested while locked");

  unlock_clear_a: assert property (
    (wr_apply && !lock_ff && !wdata_ff[ST_LOCK_BIT] && (glob_bits == GLOBAL_CLEAR))
      |=> (!any_set && !lock_ff)
  ) else $error("clear pattern did not unprotect all");

  unlock_set_a: assert property (
    (wr_apply && !lock_ff && !SUSPEND_ACTIVE_I && !wdata_ff[ST_LOCK_BIT]
      && (glob_bits == GLOBAL_SET)) |=> (all_set && !lock_ff)
  ) else $error("set pattern did not protect all");

  set_and_lock_a: assert property (
    (wr_apply && !lock_ff && !SUSPEND_ACTIVE_I && wdata_ff[ST_LOCK_BIT]
      && (glob_bits == GLOBAL_SET)) |=> (all_set && lock_ff)
  ) else $error("set and lock pattern failed");

  lock_clear_a: assert property (
    (wr_apply && soft_lock && !wdata_ff[ST_LOCK_BIT]) |=> !lock_ff
  ) else $error("lock bit not cleared with pin high");

  lock_set_a: assert property (
    (wr_apply && !lock_ff && !set_abort && wdata_ff[ST_LOCK_BIT]) |=> lock_ff
  ) else $error("lock bit not set from zero");

  lock_store_a: assert property (
    (wr_apply && !hard_lock && !set_abort) |=> (lock_ff == $past(wdata_ff[ST_LOCK_BIT]))
  ) else $error("lock bit does not hold written bit seven");

  hard_keep_a: assert property (
    (wr_apply && hard_lock) |=> (lock_ff && $stable(all_set) && $stable(any_set))
  ) else $error("status write acted under hard lock");

  short_write_a: assert property (
    (cs_end && (opcode_ff == OP_WR_STATUS) && !wdata_ok_ff)
      |=> ($stable(lock_ff) && $stable(all_set) && $stable(any_set))
  ) else $error("partial status write took effect");

  out_drive_a: assert property (
    (sck_fall && out_phase) |=> drive_ff
  ) else $error("output driver off during read phase");

  prot_all_a: assert property (
    (sck_fall && out_phase && rd_prot_ph && all_set) |=> SO_O
  ) else $error("readback low with all sectors protected");

  prot_none_a: assert property (
    (sck_fall && out_phase && rd_prot_ph && !any_set) |=> !SO_O
  ) else $error("readback high with no sector protected");

  first_bit_a: assert property (
    (sck_fall && out_phase && rd_prot_ph && (bit_cnt_ff == CNT_ADDR_DONE))
      |=> (drive_ff && (SO_O == $past(sel_bit)))
  ) else $error("first readback bit not driven");

  cnt_wrap_a: assert property (
    bit_cnt_ff <= CNT_WRAP_LAST
  ) else $error("bit counter left the repeat window");

  wp_bit_a: assert property (
    (sck_fall && out_phase && rd_stat_ph && (out_idx == 3'(ST_WP_BIT)))
      |=> (SO_O == !$past(wp_high))
  ) else $error("status read does not show pin state");
endmodule // sector_protect_lock_control

// ---- spi_host_model.sv ----
// Purpose: Serial host model for the protection block's link
// Assumes: Mode 0 framing; pins change on falling CLK_SYS edges
// Notes:   Clock rests low and data toggles while deselected
`timescale 1ns/10ps
module spi_host_model (
  input  wire logic clk_i,
  input  wire logic so_i,
  output logic      cs_n_o,
  output logic      sck_o,
  output logic      si_o
);
  initial begin
    cs_n_o = 1'b1;
    sck_o  = 1'b0;
    si_o   = 1'b0;
  end
  // Released data line keeps changing
  always @(negedge clk_i) begin
    if (cs_n_o) begin
      si_o <= ~si_o;
    end
  end
  task automatic sel();
    @(negedge clk_i);
    cs_n_o = 1'b0;
  endtask
  task automatic desel();
    @(negedge clk_i);
    cs_n_o = 1'b1;
    repeat (6) @(negedge clk_i);
  endtask
  // Shift MSB first, sample at end of high phase
  task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nbits; i--) begin
      @(negedge clk_i);
      sck_o = 1'b0;
      si_o  = tx[i];
      repeat (4) @(negedge clk_i);
      sck_o = 1'b1;
      repeat (3) @(negedge clk_i);
      rx[i] = so_i;
    end
    @(negedge clk_i);
    sck_o = 1'b0;
  endtask
  // Opcode, address or data bytes, then read bytes; last byte returned
  task automatic cmd(input logic [7:0] op, input logic [31:0] arg, input int nargb,
                     input int nrd, output logic [7:0] rx);
    logic [7:0] d;
    sel();
    xfer(op, 8, d);
    for (int b = 3; b > 3 - nargb; b--) xfer(arg[8*b +: 8], 8, d);
    for (int r = 0; r < nrd; r++) xfer(8'h00, 8, rx);
    desel();
  endtask
endmodule // spi_host_model

// ---- sector_protect_lock_control_test.sv ----
// Purpose: Self-checking bench for sector protection lock control
// Assumes: Host model in mode 0, serial clock 200 ns
// Notes:   Status bit one is masked in status byte compares
`timescale 1ns/10ps
module sector_protect_lock_control_test
  import prot_lock_pkg::*;
;
  logic       clk, nrst, wp_n, susp, cs_n, sck, si, so, so_oe, lock, write_enable_latch;
  logic [7:0] rx, got_val, eq[$];
  logic [3:0] p;
  logic [31:0] r;
  string      nq[$];
  int         failures, checks_done;
  integer     seed = 32'hc38deb41;
  event       got;
  wire        so_line = so_oe ? so : 1'bz;

  sector_protect_lock_control DUT (
    .CLK_SYS_I(clk), .NRST_I(nrst), .CS_N_I(cs_n), .SCK_I(sck), .SI_I(si),
    .WP_N_I(wp_n), .SUSPEND_ACTIVE_I(susp), .SO_O(so), .SO_OE_O(so_oe),
    .PROTECTION_LOCK_BIT_O(lock), .WRITE_ENABLE_LATCH_O(write_enable_latch));
  spi_host_model host (.clk_i(clk), .so_i(so_line), .cs_n_o(cs_n), .sck_o(sck), .si_o(si));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic cmp_byte(input string nm, input logic [7:0] e, input logic [7:0] s);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic cmp_bit(input string nm, input logic e, input logic s);
    cmp_byte(nm, {7'h00, e}, {7'h00, s});
  endtask
  task automatic give_verdict();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic note(input string nm, input logic [7:0] e, input logic [7:0] s);
    eq.push_back(e);
    nq.push_back(nm);
    got_val = s;
    -> got;
  endtask
  task automatic wr_status(input logic [7:0] d);
    host.cmd(OP_WR_ENABLE, 32'h0, 0, 0, rx);
    host.cmd(OP_WR_STATUS, {d, 24'h0}, 1, 0, rx);
  endtask
  task automatic rd_status(input logic [7:0] e);
    host.cmd(OP_RD_STATUS, 32'h0, 0, 1, rx);
    note("status byte", e & 8'hfd, rx & 8'hfd);
  endtask
  task automatic rd_prot(input logic [7:0] e);
    r = $random(seed);
    host.cmd(OP_RD_PROT, {r[23:0], 8'h00}, 3, 2, rx);
    note("protection byte", e, rx);
  endtask
  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask
  initial forever begin
    @(got);
    cmp_byte(nq.pop_front(), eq.pop_front(), got_val);
  end
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    give_verdict();
  end
  initial begin
    nrst = 1'b0;
    wp_n = 1'b1;
    susp = 1'b0;
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    rd_status(8'h0c);
    cmp_bit("lock bit", 1'b0, lock);
    done("reset");
    wr_status(8'h00);
    rd_status(8'h00);
    rd_prot(8'h00);
    r = $random(seed);
    p = (r[5:2] == 4'h0 || r[5:2] == 4'hf) ? 4'h6 : r[5:2];
    wr_status({1'b0, r[6], p, r[1:0]});
    rd_status(8'h00);
    wr_status(8'h7f);
    rd_status(8'h0c);
    rd_prot(8'hff);
    done("global");
    wr_status(8'h00);
    wr_status(8'hf0);
    rd_status(8'h80);
    wr_status(8'hff);
    rd_status(8'h80);
    wr_status(8'h7f);
    rd_status(8'h00);
    wr_status(8'h7f);
    rd_status(8'h0c);
    wr_status(8'hf0);
    wr_status(8'h0f);
    rd_status(8'h0c);
    done("soft lock");
    wr_status(8'hff);
    rd_status(8'h8c);
    cmp_bit("lock bit", 1'b1, lock);
    @(negedge clk);
    wp_n = 1'b0;
    wr_status(8'h0f);
    rd_status(8'h9c);
    wr_status(8'h00);
    rd_status(8'h9c);
    @(negedge clk);
    wp_n = 1'b1;
    wr_status(8'h0f);
    rd_status(8'h0c);
    done("hard lock");
    @(negedge clk);
    susp = 1'b1;
    wr_status(8'h00);
    wr_status(8'h7f);
    rd_status(8'h00);
    cmp_bit("write enable", 1'b0, write_enable_latch);
    @(negedge clk);
    susp = 1'b0;
    host.cmd(OP_WR_ENABLE, 32'h0, 0, 0, rx);
    host.sel();
    host.xfer(OP_WR_STATUS, 8, rx);
    host.xfer(8'h7f, 4, rx);
    host.desel();
    rd_status(8'h00);
    done("suspend and partial");
    host.sel();
    host.xfer(OP_RD_PROT, 8, rx);
    for (int i = 0; i < 3; i++) host.xfer(8'h00, 8, rx);
    host.xfer(8'h00, 3, rx);
    cmp_bit("output enable", 1'b1, so_oe);
    host.desel();
    cmp_bit("output enable", 1'b0, so_oe);
    done("abort read");
    give_verdict();
  end
endmodule // sector_protect_lock_control_test
